// ---- core/sfi_irq_regs.sv ----
// Purpose: Interrupt enable / flag bank with mailbox flag handshake
// Assumes: All event inputs are single-cycle pulses on clk_sys
// Notes:   Hardware sets win over every clear in the same cycle
`timescale 1ns/1ns

module sfi_irq_regs
  import sfi_pkg::*;
(
  input  wire logic        clk_sys,        // System clock, 125 MHz
  input  wire logic        rst,            // Synchronous reset, active high
  input  wire sfi_bus_type bus,            // Register port request
  output logic [15:0]      rdata,          // Read data, cycle after rd
  input  wire sfi_mbx_type mbx,            // Mailbox word events
  input  wire logic        mbx_wide,       // mailbox_width_sel: 1 = 32-bit
  input  wire sfi_sys_type sys,            // System event pulses
  input  wire logic        wdt_interval,   // Watchdog in interval mode
  output logic [7:0]       irq_req,        // Per-source requests
  output logic [4:0]       rst_pin_ctrl,   // reset_pin_control fields
  output logic             irq             // Event summary interrupt
);

  sfi_state_type s_q;
  sfi_state_type s_d;

  logic [AW-1:0] waddr;
  logic          wr_lo;
  logic          ifg_wr_lo;
  logic [7:0]    hw_set;
  logic [7:0]    hw_clr;
  logic [2:0]    out_wr_st;
  logic [2:0]    out_take_st;
  logic [2:0]    in_put_st;
  logic [2:0]    in_rd_st;

  // Pairs word events; returns {done, seen_next}
  function automatic logic [2:0] pair_step(logic [1:0] seen, logic [1:0] ev, logic wide);
    logic [1:0] acc;
    logic       done;
    acc  = seen | ev;
    done = wide ? (&acc) : ev[0];
    return {done, (done || !wide) ? 2'h0 : acc};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Event decode

  assign waddr     = {bus.addr[AW-1:1], 1'b0};
  assign wr_lo     = bus.wr && bus.be[0];
  assign ifg_wr_lo = wr_lo && (waddr == OFS_IFG);

  assign out_wr_st   = pair_step(s_q.out_wr_seen,
                                 {mbx.cpu_wr_out1, mbx.cpu_wr_out0}, mbx_wide);
  assign out_take_st = pair_step(s_q.out_take_seen,
                                 {mbx.dbg_take_out1, mbx.dbg_take_out0}, mbx_wide);
  assign in_put_st   = pair_step(s_q.in_put_seen,
                                 {mbx.dbg_put_in1, mbx.dbg_put_in0}, mbx_wide);
  assign in_rd_st    = pair_step(s_q.in_rd_seen,
                                 {mbx.cpu_rd_in1, mbx.cpu_rd_in0}, mbx_wide);

  always_comb begin
    hw_set         = 8'h00;
    hw_clr         = 8'h00;
    hw_set[B_MOUT] = out_take_st[2];
    hw_set[B_MIN]  = in_put_st[2];
    hw_set[B_NMI]  = sys.nmi;
    hw_set[B_VMA]  = sys.vacant;
    hw_set[B_OSC]  = sys.osc_fault;
    hw_set[B_WDT]  = sys.wdt_expire && wdt_interval;
    hw_clr[B_MOUT] = out_wr_st[2] || mbx.vec_ack_out;
    hw_clr[B_MIN]  = in_rd_st[2] || mbx.vec_ack_in;
    hw_clr[B_WDT]  = (sys.wdt_expire && !wdt_interval) || sys.wdt_serviced;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d               = s_q;
    s_d.out_wr_seen   = out_wr_st[1:0];
    s_d.out_take_seen = out_take_st[1:0];
    s_d.in_put_seen   = in_put_st[1:0];
    s_d.in_rd_seen    = in_rd_st[1:0];
    s_d.rdata         = RD_NONE;

    // Flags: hardware clear, then software write, then hardware set wins
    s_d.ifg = s_q.ifg & ~hw_clr;
    if (ifg_wr_lo) begin
      s_d.ifg = bus.wdata[7:0];
    end
    s_d.ifg = (s_d.ifg | hw_set) & IMPL_MASK;

    // Event status: write one to clear, set wins
    s_d.evt = s_q.evt;
    if (wr_lo && (waddr == OFS_EVT)) begin
      s_d.evt = s_q.evt & ~bus.wdata[7:0];
    end
    s_d.evt = (s_d.evt | hw_set) & IMPL_MASK;

    if (wr_lo) begin
      unique case (waddr)
        OFS_IE:   s_d.ie   = bus.wdata[7:0] & IMPL_MASK;
        OFS_RPCR: s_d.rpcr = bus.wdata[4:0];
        OFS_MASK: s_d.mask = bus.wdata[7:0] & IMPL_MASK;
        default:  ;
      endcase
    end

    // High lanes are all reserved, so be[1] is never decoded, for writes or for reads
    if (bus.rd) begin
      unique case (waddr)
        OFS_IE:   s_d.rdata = {8'h00, s_q.ie};
        OFS_IFG:  s_d.rdata = {8'h00, s_q.ifg};
        OFS_RPCR: s_d.rdata = {11'h000, s_q.rpcr};
        OFS_EVT:  s_d.rdata = {8'h00, s_q.evt};
        OFS_MASK: s_d.rdata = {8'h00, s_q.mask};
        default:  s_d.rdata = RD_NONE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q               <= '0;
      s_q.ie            <= IE_RST;
      s_q.ifg           <= IFG_RST;
      s_q.rpcr          <= RPCR_RST;
      s_q.evt           <= EVT_RST;
      s_q.mask          <= MASK_RST;
      s_q.rdata         <= RD_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_comb begin
    irq_req        = s_q.ifg & s_q.ie;
    // Watchdog reset mode must act even with the enable off
    irq_req[B_WDT] = s_q.ifg[B_WDT] && (s_q.ie[B_WDT] || !wdt_interval);
  end

  assign rdata        = s_q.rdata;
  assign rst_pin_ctrl = s_q.rpcr;
  // Level summary: stays up until the status bit is cleared or masked
  assign irq          = |(s_q.evt & s_q.mask);

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_ie_reset_value: assert property (disable iff (1'b0) rst |=> s_q.ie == IE_RST)
    else $error("enable register not zero after reset");
  a_ifg_reset_value: assert property (disable iff (1'b0) rst |=> s_q.ifg == IFG_RST)
    else $error("flag register not 82h after reset");
  a_reserved_read_zero: assert property (bus.rd && (waddr == OFS_IFG || waddr == OFS_IE)
    |=> rdata[15:8] == 8'h00 && rdata[5] == 1'b0 && rdata[2] == 1'b0)
    else $error("reserved bits read nonzero");
  a_high_lane_only: assert property (bus.wr && bus.be == 2'b10 |=> $stable(s_q.ie))
    else $error("high lane write changed enable byte");
  a_wdt_reset_mode: assert property (!wdt_interval && s_q.ifg[B_WDT] |-> irq_req[B_WDT])
    else $error("watchdog request gated in reset mode");
  a_out_clr_narrow: assert property (!mbx_wide && mbx.cpu_wr_out0 && !hw_set[B_MOUT]
    && !ifg_wr_lo |=> !s_q.ifg[B_MOUT])
    else $error("mailbox-out flag kept after word 0 write");
  a_out_hold_wide: assert property (mbx_wide && mbx.cpu_wr_out0 && !mbx.cpu_wr_out1
    && !s_q.out_wr_seen[1] && s_q.ifg[B_MOUT] && !mbx.vec_ack_out && !ifg_wr_lo
    |=> s_q.ifg[B_MOUT])
    else $error("mailbox-out flag cleared after one word");
  a_out_set_take: assert property (out_take_st[2] |=> s_q.ifg[B_MOUT])
    else $error("mailbox-out flag not set after take");
  a_in_clr_read: assert property (in_rd_st[2] && !in_put_st[2] && !ifg_wr_lo
    |=> !s_q.ifg[B_MIN])
    else $error("mailbox-in flag kept after read");
  a_in_set_put: assert property (in_put_st[2] |=> s_q.ifg[B_MIN])
    else $error("mailbox-in flag not set after put");
  a_vec_ack_clr: assert property (mbx.vec_ack_out && !out_take_st[2] && !ifg_wr_lo
    |=> !s_q.ifg[B_MOUT])
    else $error("vector read left mailbox-out flag set");
  a_wdt_timeout_clr: assert property (sys.wdt_expire && !wdt_interval && !ifg_wr_lo
    |=> !s_q.ifg[B_WDT])
    else $error("watchdog flag kept after timeout");
  a_vacant_set: assert property (sys.vacant |=> s_q.ifg[B_VMA])
    else $error("vacant access flag not set");
  a_req_follow: assert property (s_q.ifg[B_NMI] && s_q.ie[B_NMI] |-> irq_req[B_NMI])
    else $error("nmi request missing");

  // Register port answers
  a_rdata_idle: assert property (!bus.rd
    |=> rdata == RD_NONE)
    else $error("read data not zero outside a read answer");
  a_rdata_flags: assert property (bus.rd && waddr == OFS_IFG
    |=> rdata[7:0] == $past(s_q.ifg))
    else $error("flag read returned the wrong byte");
  a_ie_write: assert property (wr_lo && waddr == OFS_IE
    |=> s_q.ie == ($past(bus.wdata[7:0]) & IMPL_MASK))
    else $error("enable byte write not stored");
  a_ie_hold: assert property (!(wr_lo && waddr == OFS_IE)
    |=> $stable(s_q.ie))
    else $error("enable register changed without a write");
  a_mask_write: assert property (wr_lo && waddr == OFS_MASK
    |=> s_q.mask == ($past(bus.wdata[7:0]) & IMPL_MASK))
    else $error("event mask write not stored");
  a_rpcr_write: assert property (wr_lo && waddr == OFS_RPCR
    |=> rst_pin_ctrl == $past(bus.wdata[4:0]))
    else $error("reset pin control write not stored");
  a_reserved_store: assert property (
    ((s_q.ie | s_q.ifg | s_q.evt | s_q.mask) & ~IMPL_MASK) == 8'h00)
    else $error("reserved bit held a one");

  // Flag sets and software writes; set wins, so antecedents leave it out
  a_nmi_set: assert property (sys.nmi
    |=> s_q.ifg[B_NMI])
    else $error("nmi flag not set by its event");
  a_osc_set: assert property (sys.osc_fault
    |=> s_q.ifg[B_OSC])
    else $error("oscillator fault flag not set by its event");
  a_sw_flag_write: assert property (ifg_wr_lo && hw_set == 8'h00
    |=> s_q.ifg == ($past(bus.wdata[7:0]) & IMPL_MASK))
    else $error("flag byte write not stored");
  a_set_beats_write: assert property (ifg_wr_lo && sys.nmi
    |=> s_q.ifg[B_NMI])
    else $error("software write beat a hardware set");
  a_evt_vacant: assert property (sys.vacant
    |=> s_q.evt[B_VMA])
    else $error("vacant access event not recorded");
  a_evt_osc: assert property (sys.osc_fault
    |=> s_q.evt[B_OSC])
    else $error("oscillator fault event not recorded");
  a_evt_clear: assert property (wr_lo && waddr == OFS_EVT && hw_set == 8'h00
    |=> (s_q.evt & $past(bus.wdata[7:0])) == 8'h00)
    else $error("event status bit survived write one to clear");

  // Mailbox pairing
  // Trackers idle in 16-bit mode, so a stale word 1 never pairs later
  a_out_clr_wide: assert property (mbx_wide && out_wr_st[2] && !hw_set[B_MOUT]
    && !ifg_wr_lo |=> !s_q.ifg[B_MOUT])
    else $error("mailbox-out flag kept after both words");
  a_out_take_hold: assert property (mbx_wide && mbx.dbg_take_out0
    && !mbx.dbg_take_out1 && !s_q.out_take_seen[1] && !s_q.ifg[B_MOUT] && !ifg_wr_lo
    |=> !s_q.ifg[B_MOUT])
    else $error("mailbox-out flag set after one word taken");
  a_in_put_hold: assert property (mbx_wide && mbx.dbg_put_in0
    && !mbx.dbg_put_in1 && !s_q.in_put_seen[1] && !s_q.ifg[B_MIN] && !ifg_wr_lo
    |=> !s_q.ifg[B_MIN])
    else $error("mailbox-in flag set after one word written");
  a_in_rd_hold: assert property (mbx_wide && mbx.cpu_rd_in0
    && !mbx.cpu_rd_in1 && !s_q.in_rd_seen[1] && s_q.ifg[B_MIN] && !mbx.vec_ack_in
    && !ifg_wr_lo |=> s_q.ifg[B_MIN])
    else $error("mailbox-in flag cleared after one word read");
  a_vec_in_clr: assert property (mbx.vec_ack_in && !in_put_st[2] && !ifg_wr_lo
    |=> !s_q.ifg[B_MIN])
    else $error("vector read left mailbox-in flag set");
  a_narrow_idle: assert property (!mbx_wide
    |=> (s_q.out_wr_seen | s_q.out_take_seen | s_q.in_put_seen | s_q.in_rd_seen) == 2'h0)
    else $error("word tracker kept state in 16-bit mode");

  // Watchdog flag and request
  a_wdt_int_set: assert property (sys.wdt_expire && wdt_interval
    |=> s_q.ifg[B_WDT])
    else $error("interval event did not set watchdog flag");
  a_wdt_service_clr: assert property (sys.wdt_serviced && !hw_set[B_WDT]
    && !ifg_wr_lo |=> !s_q.ifg[B_WDT])
    else $error("watchdog flag kept after service");
  a_wdt_gate: assert property (wdt_interval && !s_q.ie[B_WDT]
    |-> !irq_req[B_WDT])
    else $error("interval watchdog request ignored its enable");

  // Requests and summary interrupt
  a_req_mbx_out: assert property (s_q.ifg[B_MOUT] && s_q.ie[B_MOUT]
    |-> irq_req[B_MOUT])
    else $error("mailbox-out request missing");
  a_req_masked: assert property (!s_q.ie[B_MIN]
    |-> !irq_req[B_MIN])
    else $error("mailbox-in request raised while disabled");
  a_irq_level: assert property (s_q.evt[B_NMI] && s_q.mask[B_NMI]
    |-> irq)
    else $error("summary interrupt low with an unmasked event");
  a_irq_quiet: assert property (s_q.mask == 8'h00
    |-> !irq)
    else $error("summary interrupt high with all events masked");

  c_wide_out: cover property (mbx_wide && mbx.cpu_wr_out0 ##[1:8] mbx.cpu_wr_out1);
  c_narrow_in: cover property (in_put_st[2] ##[1:8] in_rd_st[2]);
  c_irq_rise: cover property (!irq ##1 irq);
  c_vec_ack: cover property (mbx.vec_ack_in && s_q.ifg[B_MIN]);
  c_wdt_reset_mode: cover property (!wdt_interval && sys.wdt_expire);

endmodule // sfi_irq_regs

// ---- core/sfi_pkg.sv ----
// Purpose: Shared constants and carrier types for the special-function irq bank
// Assumes: 16-bit registers, byte address on the register port
// Notes:   Flag, enable, event and mask registers share one bit layout
package sfi_pkg;

  localparam int unsigned   AW        = 5;
  // Register byte offsets
  localparam logic [AW-1:0] OFS_IE    = 5'h00;
  localparam logic [AW-1:0] OFS_IFG   = 5'h02;
  localparam logic [AW-1:0] OFS_RPCR  = 5'h04;
  localparam logic [AW-1:0] OFS_EVT   = 5'h06;
  localparam logic [AW-1:0] OFS_MASK  = 5'h08;

  // Bit positions shared by enable, flag, event and mask
  localparam int unsigned   B_WDT     = 0;
  localparam int unsigned   B_OSC     = 1;
  localparam int unsigned   B_VMA     = 3;
  localparam int unsigned   B_NMI     = 4;
  localparam int unsigned   B_MIN     = 6;
  localparam int unsigned   B_MOUT    = 7;

  localparam logic [7:0]    IMPL_MASK = 8'hDB;
  localparam logic [7:0]    IE_RST    = 8'h00;
  localparam logic [7:0]    IFG_RST   = 8'h82;
  localparam logic [7:0]    EVT_RST   = 8'h00;
  localparam logic [7:0]    MASK_RST  = 8'h00;
  localparam logic [4:0]    RPCR_RST  = 5'h1C;
  localparam logic [15:0]   RD_NONE   = 16'h0000;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [15:0]   wdata;
    logic [1:0]    be;
    logic          wr;
    logic          rd;
  } sfi_bus_type;

  typedef struct packed {
    logic cpu_wr_out0;
    logic cpu_wr_out1;
    logic cpu_rd_in0;
    logic cpu_rd_in1;
    logic dbg_take_out0;
    logic dbg_take_out1;
    logic dbg_put_in0;
    logic dbg_put_in1;
    logic vec_ack_out;
    logic vec_ack_in;
  } sfi_mbx_type;

  typedef struct packed {
    logic nmi;
    logic vacant;
    logic osc_fault;
    logic wdt_expire;
    logic wdt_serviced;
  } sfi_sys_type;

  typedef struct packed {
    logic [7:0]  ie;
    logic [7:0]  ifg;
    logic [4:0]  rpcr;
    logic [7:0]  evt;
    logic [7:0]  mask;
    logic [1:0]  out_wr_seen;
    logic [1:0]  out_take_seen;
    logic [1:0]  in_put_seen;
    logic [1:0]  in_rd_seen;
    logic [15:0] rdata;
  } sfi_state_type;

endpackage

// ---- verif/sfi_mbx_model.sv ----
// Purpose: Mailbox event source standing in for the CPU and debug port
// Assumes: One request pattern at a time
// Notes:   Lag delays the pulse to mimic a slow debug port
`timescale 1ns/1ns
module sfi_mbx_model
  import sfi_pkg::*;
(
  input  wire logic       clk_sys, // System clock
  input  wire logic       rst,     // Sync reset
  input  wire logic [9:0] req,     // Event pattern, one cycle
  input  wire logic [3:0] lag,     // Cycles before the pulse
  output sfi_mbx_type     mbx      // Mailbox event pulses
);
  logic [9:0] hold_q;
  logic [3:0] cnt_q;
  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    mbx <= '0;
    if (rst) begin
      hold_q <= '0;
      cnt_q  <= '0;
    end else if (req != 10'h000) begin
      hold_q <= req;
      cnt_q  <= lag;
    end else if (hold_q != 10'h000) begin
      if (cnt_q == 4'h0) begin
        mbx    <= sfi_mbx_type'(hold_q);
        hold_q <= '0;
      end else begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule // sfi_mbx_model

// ---- verif/special_function_irq_regs_tb_top.sv ----
// Purpose: Self-checking bench for the irq enable / flag bank
// Assumes: Register port and events share clk_sys
// Notes:   Flag expectations are tracked by hand per scenario
`timescale 1ns/1ns
module special_function_irq_regs_tb_top;
  import sfi_pkg::*;
  logic        clk_sys, rst, mbx_wide, wdt_interval, irq;
  sfi_bus_type bus;
  sfi_mbx_type mbx;
  sfi_sys_type sys;
  logic [15:0] rdata, got;
  logic [7:0]  irq_req;
  logic [4:0]  rst_pin_ctrl;
  logic [9:0]  req;
  logic [3:0]  lag;
  int          errors, compares;
  localparam logic [9:0] MV [0:15] = '{10'h008, 10'h080, 10'h020, 10'h200,
    10'h020, 10'h010, 10'h200, 10'h100, 10'h008, 10'h004, 10'h080, 10'h040,
    10'h00C, 10'h001, 10'h030, 10'h002};
  localparam logic [7:0] MX [0:15] = '{8'h40, 8'h00, 8'h80, 8'h00, 8'h00,
    8'h80, 8'h80, 8'h00, 8'h00, 8'h40, 8'h40, 8'h00, 8'h40, 8'h00, 8'h80, 8'h00};

  sfi_irq_regs u_sfi_irq_regs (.clk_sys(clk_sys), .rst(rst), .bus(bus),
    .rdata(rdata), .mbx(mbx), .mbx_wide(mbx_wide), .sys(sys),
    .wdt_interval(wdt_interval), .irq_req(irq_req),
    .rst_pin_ctrl(rst_pin_ctrl), .irq(irq));
  sfi_mbx_model u_sfi_mbx_model (.clk_sys(clk_sys), .rst(rst), .req(req),
    .lag(lag), .mbx(mbx));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d,
                     input logic [1:0] b);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, be: b, wr: w, rd: !w};
    @(posedge clk_sys);
    bus <= '0;
    #1 got = rdata;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000, 2'h0);
    chk("rdata", e, got);
  endtask
  task automatic sp(input sfi_sys_type s);
    @(posedge clk_sys);
    sys <= s;
    @(posedge clk_sys);
    sys <= '0;
  endtask
  task automatic ev(input logic [9:0] m, input logic [3:0] l, input logic wd);
    @(posedge clk_sys);
    req      <= m;
    lag      <= l;
    mbx_wide <= wd;
    @(posedge clk_sys);
    req <= '0;
    repeat (l + 2) @(posedge clk_sys);
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_chk(OFS_IE, 16'h0000);
    rd_chk(OFS_IFG, 16'h0082);
    rd_chk(OFS_RPCR, 16'h001C);
    chk("irq_req", 16'h0000, {8'h00, irq_req});
  endtask
  task automatic t_regs;
    acc(1'b1, OFS_IE, 16'hFFFF, 2'h3);
    rd_chk(OFS_IE, 16'h00DB);
    acc(1'b1, OFS_IE, 16'h0000, 2'h2);
    rd_chk(OFS_IE, 16'h00DB);
    acc(1'b1, OFS_IFG, 16'hFFDB, 2'h1);
    rd_chk(OFS_IFG, 16'h00DB);
    chk("irq_req", 16'h00DB, {8'h00, irq_req});
    acc(1'b1, OFS_IE, 16'h00DA, 2'h1);
    chk("irq_req", 16'h00DA, {8'h00, irq_req});
    @(posedge clk_sys);
    wdt_interval <= 1'b0;
    #1 chk("irq_req", 16'h00DB, {8'h00, irq_req});
    acc(1'b1, OFS_IFG, 16'h0000, 2'h1);
    rd_chk(OFS_IFG, 16'h0000);
    acc(1'b1, OFS_RPCR, 16'h0003, 2'h3);
    chk("rst_pin_ctrl", 16'h0003, {11'h000, rst_pin_ctrl});
    acc(1'b1, 5'h0A, 16'hFFFF, 2'h3);
    rd_chk(5'h0A, 16'h0000);
  endtask
  task automatic t_events;
    sp(5'b11100);
    rd_chk(OFS_IFG, 16'h001A);
    chk("irq", 16'h0000, {15'h0000, irq});
    acc(1'b1, OFS_MASK, 16'h00FF, 2'h1);
    chk("irq", 16'h0001, {15'h0000, irq});
    acc(1'b1, OFS_EVT, 16'h00FF, 2'h1);
    chk("irq", 16'h0000, {15'h0000, irq});
    acc(1'b1, OFS_IFG, 16'h0000, 2'h1);
    // Flag write and hardware set in one cycle: the set must win
    @(posedge clk_sys);
    bus <= '{addr: OFS_IFG, wdata: 16'h0000, be: 2'h1, wr: 1'b1, rd: 1'b0};
    sys <= 5'b10000;
    @(posedge clk_sys);
    bus <= '0;
    sys <= '0;
    rd_chk(OFS_IFG, 16'h0010);
    chk("irq", 16'h0001, {15'h0000, irq});
    acc(1'b1, OFS_IFG, 16'h0000, 2'h1);
  endtask
  task automatic t_mbx;
    for (int i = 0; i < 16; i++) begin
      ev(MV[i], (i % 2 == 1) ? 4'h3 : 4'h0, i >= 4);
      rd_chk(OFS_IFG, {8'h00, MX[i]});
    end
  endtask
  task automatic t_wdt;
    @(posedge clk_sys);
    wdt_interval <= 1'b1;
    sp(5'b00010);
    rd_chk(OFS_IFG, 16'h0001);
    sp(5'b00001);
    rd_chk(OFS_IFG, 16'h0000);
    @(posedge clk_sys);
    wdt_interval <= 1'b0;
    acc(1'b1, OFS_IFG, 16'h0001, 2'h1);
    sp(5'b00010);
    rd_chk(OFS_IFG, 16'h0000);
  endtask
  task automatic finish_test;
    if (errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    finish_test();
  end
  initial begin
    errors = 0;
    compares = 0;
    rst = 1'b1;
    bus = '0;
    sys = '0;
    req = '0;
    lag = '0;
    mbx_wide = 1'b0;
    wdt_interval = 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_events();
    t_mbx();
    t_wdt();
    // Mid-run reset must bring IE, IFG and RPCR back to their reset values, with irq_req clear
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    finish_test();
  end
endmodule // special_function_irq_regs_tb_top
